// ### src/stpo_regs.svh
`ifndef STPO_REGS_SVH
`define STPO_REGS_SVH

// word and byte geometry of the parallel port
`define STPO_WORD_BITS 16
`define STPO_BYTE_BITS 8
`define STPO_BIT_CNT_W 5

// decimation counter: ratio is 2 to the power (n+1), n from 0 to 11
`define STPO_DEC_N_W 4
`define STPO_DEC_N_MAX 4'hB
`define STPO_DEC_CNT_W 13

// baud divider: source divided by 2 to the power n, n from 8 to 12
`define STPO_BAUD_N_MIN 4'h8
`define STPO_BAUD_N_MAX 4'hC
`define STPO_BAUD_CNT_W 12

// board clock and on-board oscillator rates in hertz
`define STPO_CLK_HZ 20000000
`define STPO_OSC_HZ 4915200
// phase accumulator that makes the oscillator-rate enable from ref_clk
`define STPO_PHASE_W 24
`define STPO_PHASE_INC ((64'(`STPO_OSC_HZ) << `STPO_PHASE_W) / 64'(`STPO_CLK_HZ))

// output buffer depth
`define STPO_BUF_DEPTH 2

// positions in the pin synchroniser vector
`define STPO_SY_WA 0
`define STPO_SY_CSCLK 1
`define STPO_SY_SDATA 2
`define STPO_SY_RSEL 3
`define STPO_SY_RCLK 4
`define STPO_SY_RDEN 5
`define STPO_SY_BSEL 6
`define STPO_SY_ACK 7
`define STPO_SYNC_N 8

`endif

// ### src/stpo_pkg.sv
package stpo_pkg;

  // converter output mode jumper
  typedef enum logic [1:0] {
    STPO_SELF_CLOCKED,
    STPO_EXTERNAL_CLOCKED,
    STPO_ASYNC_CHAR
  } stpo_mode_t;

  // capture sequencer states
  typedef enum logic [1:0] {
    STPO_CAP_IDLE,
    STPO_CAP_SHIFT,
    STPO_CAP_SKIP
  } stpo_cap_t;

endpackage : stpo_pkg

// ### src/stpo_pair_buf.sv
`timescale 1ns/100ps
`include "stpo_regs.svh"

module stpo_pair_buf #(
  parameter int WIDTH = `STPO_WORD_BITS,
  parameter int DEPTH = `STPO_BUF_DEPTH
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH]; // entry storage
  logic [PW-1:0] wr_q; // write pointer
  logic [PW-1:0] rd_q; // read pointer
  logic [CW-1:0] cnt_q; // entries held
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire [PW-1:0] wr_nx = (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
  wire [PW-1:0] rd_nx = (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;

  // honest flags straight from the count
  assign in_ready = (cnt_q != CW'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];

  ////////////////////////////////////////////////////////////////////////////
  // storage has no reset: only entries below the count are ever read
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_nx;
      end
      if (pop) begin
        rd_q <= rd_nx;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule : stpo_pair_buf

// ### src/stpo_port.sv
`timescale 1ns/100ps
`include "stpo_regs.svh"

module stpo_port
  import stpo_pkg::*;
#(
  parameter int WORD_BITS = `STPO_WORD_BITS
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire stpo_mode_t mode, // converter output mode jumper
  input wire logic decimation_drive_select, // decimation counter drives select
  input wire logic baud_clock_route, // on-board baud clock to converter
  input wire logic lockout_enable, // low when lockout link removed
  input wire logic byte_wide_enable, // two 8-bit reads
  input wire logic [`STPO_DEC_N_W-1:0] decim_ratio_sel, // n, ratio 2^(n+1)
  input wire logic [`STPO_DEC_N_W-1:0] baud_div_sel, // n, divide by 2^n
  input wire logic word_available_n, // converter data ready pin
  input wire logic conv_sclk_i, // converter serial clock pin, in
  output logic conv_sclk_o, // converter serial clock pin, out
  output logic conv_sclk_oe, // high while we drive it
  input wire logic conv_sdata, // converter serial data pin
  output logic converter_select_n, // select applied to converter
  input wire logic remote_select_n, // select from the controller
  input wire logic serial_clock_in, // clock from the controller
  output logic result_ready_n, // data ready shown to controller
  output logic serial_out_line, // serial data shown to controller
  output logic decimated_select_strobe, // strobe, high when idle
  output logic clear_to_send_n, // serial port clear-to-send
  input wire logic read_enable_n, // reader output enable
  input wire logic byte_select_line, // picks byte in byte mode
  input wire logic reader_acknowledge, // reader done
  output logic parallel_word_ready, // new word held
  output logic [WORD_BITS-1:0] par_data, // parallel bus value
  output logic par_oe_lo, // drive low byte lane
  output logic par_oe_hi // drive high byte lane
);

  localparam int BW = `STPO_BYTE_BITS;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three flops, change taken when 2nd and 3rd agree
  wire [`STPO_SYNC_N-1:0] pin_raw = {reader_acknowledge, byte_select_line, read_enable_n,
    serial_clock_in, remote_select_n, conv_sdata, conv_sclk_i, word_available_n};
  logic [`STPO_SYNC_N-1:0] pin_f; // filtered pin levels

  genvar gi;
  generate
    for (gi = 0; gi < `STPO_SYNC_N; gi++) begin : g_sync
      logic s1_q; // first stage, read only by s2
      logic s2_q;
      logic s3_q;
      logic f_q;
      // idle level one so low-active pins start inactive
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          s1_q <= 1'b1;
          s2_q <= 1'b1;
          s3_q <= 1'b1;
          f_q <= 1'b1;
        end else begin
          s1_q <= pin_raw[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            f_q <= s3_q;
          end
        end
      end
      assign pin_f[gi] = f_q;
    end
  endgenerate

  // named views of the filtered pins
  wire wa_f = pin_f[`STPO_SY_WA];
  wire csclk_f = pin_f[`STPO_SY_CSCLK];
  wire sdata_f = pin_f[`STPO_SY_SDATA];
  wire rsel_f = pin_f[`STPO_SY_RSEL];
  wire rclk_f = pin_f[`STPO_SY_RCLK];
  wire rden_f = pin_f[`STPO_SY_RDEN];
  wire bsel_f = pin_f[`STPO_SY_BSEL];
  wire ack_f = pin_f[`STPO_SY_ACK];

  // edge history for the filtered pins and the applied select
  logic wa_d1_q; // data ready last cycle
  logic csclk_d1_q; // converter clock last cycle
  logic ack_d1_q; // acknowledge last cycle
  logic sel_d1_q; // applied select last cycle
  wire wa_fall = wa_d1_q && !wa_f;
  wire wa_rise = !wa_d1_q && wa_f;
  wire csclk_rise = !csclk_d1_q && csclk_f;
  wire ack_rise = !ack_d1_q && ack_f;

  ////////////////////////////////////////////////////////////////////////////
  // baud clock: oscillator-rate enable, then binary divider
  logic [`STPO_PHASE_W-1:0] phase_q; // fractional oscillator phase
  logic [`STPO_BAUD_CNT_W-1:0] baud_cnt_q; // divider chain
  logic baud_clk_q; // selected tap
  localparam logic [`STPO_PHASE_W:0] PHASE_INC = (`STPO_PHASE_W + 1)'(`STPO_PHASE_INC);
  wire [`STPO_PHASE_W:0] phase_sum = {1'b0, phase_q} + PHASE_INC;
  wire osc_tick = phase_sum[`STPO_PHASE_W];
  // out-of-range selections clamp to the nearest legal tap
  wire [`STPO_DEC_N_W-1:0] baud_n = (baud_div_sel < `STPO_BAUD_N_MIN) ? `STPO_BAUD_N_MIN :
    (baud_div_sel > `STPO_BAUD_N_MAX) ? `STPO_BAUD_N_MAX : baud_div_sel;
  wire baud_tap = baud_cnt_q[baud_n - 4'h1];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      phase_q <= '0;
      baud_cnt_q <= '0;
      baud_clk_q <= 1'b0;
    end else begin
      phase_q <= phase_sum[`STPO_PHASE_W-1:0];
      if (osc_tick) begin
        baud_cnt_q <= baud_cnt_q + 1'b1;
      end
      baud_clk_q <= baud_tap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decimation counter: counts ready falls, enables select at 2^(n+1)
  logic [`STPO_DEC_CNT_W-1:0] dec_cnt_q; // ready pulses seen
  logic dec_sel_n_q; // counter's select output
  // remote select means position zero, one strobe per activation
  wire dec_drive = decimation_drive_select && (mode != STPO_EXTERNAL_CLOCKED);
  wire [`STPO_DEC_N_W-1:0] dec_n = !dec_drive ? '0 :
    (decim_ratio_sel > `STPO_DEC_N_MAX) ? `STPO_DEC_N_MAX : decim_ratio_sel;
  wire [`STPO_DEC_CNT_W-1:0] dec_ratio = `STPO_DEC_CNT_W'(2) << dec_n;
  wire [`STPO_DEC_CNT_W-1:0] dec_cnt_nx = dec_cnt_q + 1'b1;

  // a ready fall only happens once the converter port was emptied
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dec_cnt_q <= '0;
      dec_sel_n_q <= 1'b1;
    end else if (!dec_sel_n_q && wa_rise) begin
      dec_cnt_q <= '0;
      dec_sel_n_q <= 1'b1;
    end else if (wa_fall && dec_sel_n_q) begin
      dec_cnt_q <= dec_cnt_nx;
      if (dec_cnt_nx >= dec_ratio) begin
        dec_sel_n_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // converter pin routing
  logic conv_sel_n_q; // select applied to the converter
  logic conv_sclk_o_q; // clock we give the converter
  logic conv_sclk_oe_q; // we own the clock pin
  logic cts_n_q; // clear-to-send level
  // the counter owns select only when routed and not in external mode
  wire sel_src = dec_drive ? dec_sel_n_q : rsel_f;
  // external mode takes the controller clock; async picks baud or remote
  wire use_baud = (mode == STPO_ASYNC_CHAR) && baud_clock_route;
  wire sclk_src = use_baud ? baud_clk_q : rclk_f;
  // self-clocked mode leaves the pin to the converter
  wire sclk_own = (mode != STPO_SELF_CLOCKED);
  // with decimation, clear-to-send follows the thinned select
  wire cts_src = dec_drive ? dec_sel_n_q : wa_f;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      conv_sel_n_q <= 1'b1;
      conv_sclk_o_q <= 1'b0;
      conv_sclk_oe_q <= 1'b0;
      cts_n_q <= 1'b1;
    end else begin
      conv_sel_n_q <= sel_src;
      conv_sclk_o_q <= sclk_src;
      conv_sclk_oe_q <= sclk_own;
      cts_n_q <= cts_src;
    end
  end

  // async frames (start, 8 data, 2 stop, two per result) pass unaltered
  assign serial_out_line = sdata_f;
  assign result_ready_n = wa_f;
  assign converter_select_n = conv_sel_n_q;
  assign decimated_select_strobe = conv_sel_n_q;
  assign conv_sclk_o = conv_sclk_o_q;
  assign conv_sclk_oe = conv_sclk_oe_q;
  assign clear_to_send_n = cts_n_q;

  ////////////////////////////////////////////////////////////////////////////
  // capture sequencer: one attempt per select activation
  stpo_cap_t cap_q; // sequencer state
  stpo_cap_t cap_d;
  logic [WORD_BITS-1:0] shift_q; // two cascaded byte shifters
  logic [`STPO_BIT_CNT_W-1:0] bit_cnt_q; // bits taken this frame
  logic hs_q; // handshake flop, drives ready
  logic buf_in_ready; // buffer has room
  logic buf_out_valid; // buffer has a word
  logic [WORD_BITS-1:0] buf_out_data;
  wire sel_fall = sel_d1_q && !conv_sel_n_q;
  wire sel_rise = !sel_d1_q && conv_sel_n_q;
  // inverted handshake output gates loading unless the link is removed
  wire locked = lockout_enable && hs_q;
  wire accept_ok = (mode == STPO_SELF_CLOCKED) && buf_in_ready && !locked;
  wire word_done = (bit_cnt_q == `STPO_BIT_CNT_W'(WORD_BITS));
  // a short frame is dropped; only a full word is pushed
  wire buf_in_valid = (cap_q == STPO_CAP_SHIFT) && sel_rise && word_done;

  // next state
  always_comb begin
    cap_d = cap_q;
    case (cap_q)
      STPO_CAP_IDLE: begin
        if (sel_fall) begin
          cap_d = accept_ok ? STPO_CAP_SHIFT : STPO_CAP_SKIP;
        end
      end
      STPO_CAP_SHIFT, STPO_CAP_SKIP: begin
        if (sel_rise) begin
          cap_d = STPO_CAP_IDLE;
        end
      end
      default: begin
        cap_d = STPO_CAP_IDLE;
      end
    endcase
  end

  // shifting on converter clock rising edges, msb first
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cap_q <= STPO_CAP_IDLE;
      shift_q <= '0;
      bit_cnt_q <= '0;
    end else begin
      cap_q <= cap_d;
      if (sel_fall) begin
        bit_cnt_q <= '0;
      end else if (cap_q == STPO_CAP_SHIFT && csclk_rise && !word_done) begin
        shift_q <= {shift_q[WORD_BITS-2:0], sdata_f};
        bit_cnt_q <= bit_cnt_q + 1'b1;
      end
    end
  end

  // edge history
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wa_d1_q <= 1'b1;
      csclk_d1_q <= 1'b1;
      ack_d1_q <= 1'b1;
      sel_d1_q <= 1'b1;
    end else begin
      wa_d1_q <= wa_f;
      csclk_d1_q <= csclk_f;
      ack_d1_q <= ack_f;
      sel_d1_q <= conv_sel_n_q;
    end
  end

  // two-entry buffer; a frame starting while the word is locked is skipped, so a reader stall still loses words
  stpo_pair_buf #(
    .WIDTH(WORD_BITS),
    .DEPTH(`STPO_BUF_DEPTH)
  ) u_buf (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(shift_q),
    .out_valid(buf_out_valid),
    .out_ready(!locked),
    .out_data(buf_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // output holding registers and handshake flop
  logic [WORD_BITS-1:0] hold_q; // word the reader sees
  wire hold_load = buf_out_valid && !locked;

  // a new word sets the flag even in the cycle an acknowledge lands
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hold_q <= '0;
      hs_q <= 1'b0;
    end else begin
      if (hold_load) begin
        hold_q <= buf_out_data;
        hs_q <= 1'b1;
      end else if (ack_rise) begin
        hs_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // parallel bus: byte mode puts the chosen register on the low lane
  logic [WORD_BITS-1:0] par_q; // registered bus value
  wire rd_on = !rden_f;
  wire [BW-1:0] byte_pick = bsel_f ? hold_q[WORD_BITS-1:BW] : hold_q[BW-1:0];
  wire [WORD_BITS-1:0] par_nx = byte_wide_enable ? {BW'(0), byte_pick} : hold_q;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      par_q <= '0;
    end else begin
      par_q <= par_nx;
    end
  end

  assign par_data = par_q;
  assign par_oe_lo = rd_on;
  assign par_oe_hi = rd_on && !byte_wide_enable;
  assign parallel_word_ready = hs_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_hs_set_on_load: assert property (@(posedge ref_clk) disable iff (!nrst)
    hold_load |=> hs_q && parallel_word_ready)
    else $error("ready flag not set after load");
  a_hs_clear_ack: assert property (@(posedge ref_clk) disable iff (!nrst)
    (ack_rise && !hold_load) |=> !parallel_word_ready)
    else $error("ready flag not cleared by acknowledge");
  a_lockout_holds: assert property (@(posedge ref_clk) disable iff (!nrst)
    (lockout_enable && hs_q && !ack_rise) |=> $stable(hold_q))
    else $error("held word changed while locked");
  a_skip_locked: assert property (@(posedge ref_clk) disable iff (!nrst)
    (cap_q == STPO_CAP_IDLE && sel_fall && lockout_enable && hs_q) |=> cap_q == STPO_CAP_SKIP)
    else $error("locked attempt not discarded");
  a_push_full_word: assert property (@(posedge ref_clk) disable iff (!nrst)
    buf_in_valid |-> bit_cnt_q == 5'h10 && $past(!conv_sel_n_q))
    else $error("pushed word not sixteen bits");
  a_oe_off_idle: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(rden_f) |-> !par_oe_lo && !par_oe_hi)
    else $error("bus driven without reader enable");
  a_ext_select: assert property (@(posedge ref_clk) disable iff (!nrst)
    (mode == STPO_EXTERNAL_CLOCKED) [*2] |-> converter_select_n == $past(rsel_f) && conv_sclk_oe)
    else $error("external mode not under controller");
  a_dec_release: assert property (@(posedge ref_clk) disable iff (!nrst)
    (dec_drive && !dec_sel_n_q && wa_rise) |=> dec_sel_n_q && dec_cnt_q == 13'h0000 ##1 converter_select_n)
    else $error("decimation select not released");
  a_byte_lane: assert property (@(posedge ref_clk) disable iff (!nrst)
    (byte_wide_enable && $stable(byte_wide_enable)) |-> par_data[15:8] == 8'h00 && !par_oe_hi)
    else $error("high lane active in byte mode");

endmodule : stpo_port

// ### testbench/stpo_reader_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// remote parallel reader: waits for the ready flag, reads, then acknowledges
module stpo_reader_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic en, // reader willing to read
  input wire logic byte_mode, // two byte reads on the low lane
  input wire logic [7:0] delay, // idle cycles before a read, for a slow reader
  input wire logic parallel_word_ready,
  input wire logic [15:0] par_data,
  input wire logic par_oe_lo,
  input wire logic par_oe_hi,
  output logic read_enable_n,
  output logic byte_select_line,
  output logic reader_acknowledge,
  output logic [15:0] got_word,
  output logic [7:0] n_words
);
  // an undriven lane reads as unknown, so a read without enable never matches
  function automatic logic [7:0] lane(input logic oe, input logic [7:0] v);
    return (oe === 1'b1) ? v : 8'hXX;
  endfunction : lane

  ////////////////////////////////////////////////////////////////////////////////
  // read loop; pins move 5 ns after an edge, so the block samples them settled
  initial begin
    read_enable_n = 1'b1;
    byte_select_line = 1'b1;
    reader_acknowledge = 1'b0;
    got_word = 16'h0000;
    n_words = 8'h00;
    forever begin
      @(posedge ref_clk);
      #5;
      if (nrst === 1'b1 && en === 1'b1 && parallel_word_ready === 1'b1) begin
        repeat (delay) @(posedge ref_clk);
        read_enable_n = 1'b0;
        repeat (8) @(posedge ref_clk);
        #5;
        if (byte_mode) begin
          got_word[15:8] = lane(par_oe_lo, par_data[7:0]);
          byte_select_line = 1'b0;
          repeat (8) @(posedge ref_clk);
          #5;
          got_word[7:0] = lane(par_oe_lo, par_data[7:0]);
          // the idle high lane must stay released in byte mode
          if (par_oe_hi !== 1'b0) got_word = 16'hXXXX;
          byte_select_line = 1'b1;
        end else begin
          got_word = {lane(par_oe_hi, par_data[15:8]), lane(par_oe_lo, par_data[7:0])};
        end
        // acknowledge only after the read, between frames
        read_enable_n = 1'b1;
        reader_acknowledge = 1'b1;
        repeat (4) @(posedge ref_clk);
        #5;
        reader_acknowledge = 1'b0;
        n_words = n_words + 8'h01;
        repeat (12) @(posedge ref_clk);
      end
    end
  end
endmodule : stpo_reader_model

// ### testbench/tb_stpo_port.sv
`timescale 1ns/100ps
module tb_stpo_port import stpo_pkg::*; ;
  logic ref_clk, nrst, decimation_drive_select, baud_clock_route, lockout_enable, byte_wide_enable;
  stpo_mode_t mode;
  logic [3:0] decim_ratio_sel, baud_div_sel;
  logic word_available_n, conv_sclk_i, conv_sclk_o, conv_sclk_oe, conv_sdata, converter_select_n;
  logic remote_select_n, serial_clock_in, result_ready_n, serial_out_line, decimated_select_strobe;
  logic clear_to_send_n, read_enable_n, byte_select_line, reader_acknowledge, parallel_word_ready;
  logic [15:0] par_data, got_word;
  logic par_oe_lo, par_oe_hi, en;
  logic [7:0] delay, n_words;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int c;
  real exp_c;

  stpo_port dut (.ref_clk(ref_clk), .nrst(nrst), .mode(mode), .decimation_drive_select(decimation_drive_select),
    .baud_clock_route(baud_clock_route), .lockout_enable(lockout_enable), .byte_wide_enable(byte_wide_enable),
    .decim_ratio_sel(decim_ratio_sel), .baud_div_sel(baud_div_sel), .word_available_n(word_available_n),
    .conv_sclk_i(conv_sclk_i), .conv_sclk_o(conv_sclk_o), .conv_sclk_oe(conv_sclk_oe), .conv_sdata(conv_sdata),
    .converter_select_n(converter_select_n), .remote_select_n(remote_select_n), .serial_clock_in(serial_clock_in),
    .result_ready_n(result_ready_n), .serial_out_line(serial_out_line),
    .decimated_select_strobe(decimated_select_strobe), .clear_to_send_n(clear_to_send_n),
    .read_enable_n(read_enable_n), .byte_select_line(byte_select_line), .reader_acknowledge(reader_acknowledge),
    .parallel_word_ready(parallel_word_ready), .par_data(par_data), .par_oe_lo(par_oe_lo), .par_oe_hi(par_oe_hi));

  stpo_reader_model reader (.ref_clk(ref_clk), .nrst(nrst), .en(en), .byte_mode(byte_wide_enable), .delay(delay),
    .parallel_word_ready(parallel_word_ready), .par_data(par_data), .par_oe_lo(par_oe_lo), .par_oe_hi(par_oe_hi),
    .read_enable_n(read_enable_n), .byte_select_line(byte_select_line), .reader_acknowledge(reader_acknowledge),
    .got_word(got_word), .n_words(n_words));

  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard; the baud periods dominate the run time
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      $display("timeout at %0t", $time);
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #5;
  endtask : step

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one self-clocked frame, msb first, each level held 4 cycles for the filter
  task automatic send_word(input logic [15:0] w);
    remote_select_n = 1'b0;
    step(8);
    chk(decimated_select_strobe, 1'b0);
    for (int i = 15; i >= 0; i--) begin
      conv_sdata = w[i];
      step(4);
      conv_sclk_i = 1'b1;
      step(4);
      conv_sclk_i = 1'b0;
    end
    step(4);
    conv_sdata = ~w[0]; // released data line does not keep its last value
    remote_select_n = 1'b1;
    step(10);
  endtask : send_word

  task automatic wait_words(input logic [7:0] target);
    int k;
    k = 0;
    while (n_words !== target && k < 800) begin
      step(1);
      k++;
    end
    chk(n_words, target);
  endtask : wait_words

  task automatic next_rise(output int cyc);
    logic prev;
    cyc = 0;
    do begin
      prev = conv_sclk_o;
      step(1);
      cyc++;
    end while (!(prev === 1'b0 && conv_sclk_o === 1'b1) && cyc < 20000);
  endtask : next_rise

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    mode = STPO_SELF_CLOCKED;
    {decimation_drive_select, baud_clock_route, byte_wide_enable, conv_sclk_i, conv_sdata} = 5'h00;
    {lockout_enable, word_available_n, remote_select_n, serial_clock_in, en} = 5'h1F;
    decim_ratio_sel = 4'h0;
    baud_div_sel = 4'h8;
    delay = 8'h00;
    step(6);
    chk(parallel_word_ready, 1'b0);
    chk({par_oe_hi, par_oe_lo, conv_sclk_oe}, 16'h0000);
    nrst = 1'b1;
    step(6);
    send_word(16'hA5C3);
    wait_words(8'h01);
    chk(got_word, 16'hA5C3);
    step(12);
    chk(parallel_word_ready, 1'b0);
    $display("test single word done");
    en = 1'b0;
    send_word(16'h1234);
    chk(parallel_word_ready, 1'b1);
    chk({par_oe_hi, par_oe_lo}, 16'h0000);
    send_word(16'hFEDC);
    en = 1'b1;
    wait_words(8'h02);
    chk(got_word, 16'h1234);
    step(60);
    chk(parallel_word_ready, 1'b0);
    send_word(16'h8001);
    wait_words(8'h03);
    chk(got_word, 16'h8001);
    $display("test lockout done");
    byte_wide_enable = 1'b1;
    delay = 8'h28;
    send_word(16'h3C96);
    wait_words(8'h04);
    chk(got_word, 16'h3C96);
    byte_wide_enable = 1'b0;
    delay = 8'h00;
    step(12);
    $display("test byte read done");
    // lockout link removed: a later word replaces the unread one
    lockout_enable = 1'b0;
    en = 1'b0;
    send_word(16'h5AA5);
    send_word(16'h0FF0);
    chk(parallel_word_ready, 1'b1);
    en = 1'b1;
    wait_words(8'h05);
    chk(got_word, 16'h0FF0);
    lockout_enable = 1'b1;
    step(12);
    chk(parallel_word_ready, 1'b0);
    $display("test lockout removed done");
    decimation_drive_select = 1'b1;
    for (int p = 0; p < 2; p++) begin
      word_available_n = 1'b0;
      step(10);
      chk(converter_select_n, 16'(p == 0));
      chk(decimated_select_strobe, 16'(p == 0));
      chk(clear_to_send_n, 16'(p == 0));
      word_available_n = 1'b1;
      step(10);
      chk(converter_select_n, 1'b1);
    end
    decimation_drive_select = 1'b0;
    $display("test decimation done");
    for (int m = 1; m < 3; m++) begin
      for (int v = 0; v < 2; v++) begin
        mode = stpo_mode_t'(m);
        decimation_drive_select = (m == 1);
        {serial_clock_in, conv_sdata, word_available_n, remote_select_n} = {4{v[0]}};
        step(10);
        chk(conv_sclk_oe, 1'b1);
        chk(conv_sclk_o, v[0]);
        chk({serial_out_line, result_ready_n, converter_select_n}, {3{v[0]}});
        if (m == 2) chk(clear_to_send_n, v[0]);
      end
    end
    $display("test routing done");
    baud_clock_route = 1'b1;
    for (int n = 8; n < 11; n++) begin
      baud_div_sel = 4'(n);
      next_rise(c);
      next_rise(c);
      exp_c = (2.0 ** n) * 20.0 / 4.9152;
      chk(16'(c >= $rtoi(exp_c) - 1 && c <= $rtoi(exp_c) + 2), 1'b1);
    end
    $display("test baud divider done");
    conclude();
  end
endmodule : tb_stpo_port
